//--- tb/daq_bus_asserts.sv
// Concurrent checks on the register bus joining host and device ends
`timescale 1ns/10ps
`include "daq_map.svh"
module daq_bus_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus signals
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic irq
);
  // ==========================================
  // Shadow state
  logic [7:0] chan;
  logic [7:0] gain;
  logic [7:0] ctrl;
  logic [1:0] page;
  logic [9:0] settle;
  wire wr0 = bus_wr && bus_addr == `DAQ_OFS_CMD;
  wire brd = wr0 && bus_wdata[`DAQ_CMD_BOARD];
  wire clr = wr0 && (bus_wdata[3:0] != 4'h0 || brd);
  wire ldw = bus_wr && (bus_addr == `DAQ_OFS_CHAN || bus_addr == `DAQ_OFS_GAIN);
  wire pgw = bus_wr && bus_addr == `DAQ_OFS_PAGE;
  always_ff @(posedge core_clk) begin
    if (rst || brd) begin
      chan <= 8'h00;
      gain <= 8'h00;
      ctrl <= 8'h00;
      page <= 2'h0;
    end else if (bus_wr) begin
      if (bus_addr == `DAQ_OFS_CHAN) chan <= bus_wdata;
      if (bus_addr == `DAQ_OFS_GAIN) gain <= bus_wdata & 8'h07;
      if (bus_addr == `DAQ_OFS_GAIN) page <= bus_wdata[5:4];
      if (bus_addr == `DAQ_OFS_CTRL) ctrl <= bus_wdata & 8'h21;
      if (pgw && bus_wdata != 8'hA5 && bus_wdata != 8'hA6) page <= bus_wdata[1:0];
    end
  end
  // Margin of two cycles either side of the 400-cycle settle
  always_ff @(posedge core_clk) begin
    if (rst || brd) settle <= 10'h000;
    else if (ldw) settle <= 10'h192;
    else if (settle != 10'h000) settle <= settle - 10'h001;
  end
  // ==========================================
  // Properties
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [3:0] a);
    bus_rd && bus_addr == a;
  endsequence
  a_chan_readback: assert property (s_rd(4'h2) |=> bus_rdata == chan)
    else $error("channel readback differs");
  a_settle_raised: assert property (s_rd(4'h3) ##0 settle > 10'h004 |=> bus_rdata[5])
    else $error("settling flag low too early");
  a_settle_ends: assert property (s_rd(4'h3) ##0 settle == 10'h000 |=> !bus_rdata[5])
    else $error("settling flag held too long");
  a_gain_readback: assert property (s_rd(4'h3) |=> bus_rdata[4:0] == gain[4:0])
    else $error("gain and scan readback differs");
  a_ctrl_readback: assert property (s_rd(4'h4) |=> bus_rdata == ctrl)
    else $error("control readback differs");
  a_page_gate: assert property (s_rd(4'hE) ##0 page != 2'h2 |=> bus_rdata == 8'h00)
    else $error("page two register seen off page two");
  a_irq_clears: assert property (wr0 && bus_wdata[3:0] == 4'hF |-> ##[1:2] !irq)
    else $error("request line not cleared");
  a_board_quiet: assert property (brd |-> ##[1:2] !irq)
    else $error("board reset left request line up");
  a_irq_holds: assert property (irq && !clr && !$past(clr) |=> irq)
    else $error("request line dropped without a clear");
endmodule // daq_bus_asserts

//--- tb/test_daq_analog_input_command_regs.sv
// Testbench joining host and device ends of the acquisition block
`timescale 1ns/10ps
module test_daq_analog_input_command_regs;
  import daq_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] cmd_addr = 3'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [7:0] cmd_rdata;
  logic enh = 1'b1;
  logic trig_a = 1'b0, trig_b = 1'b0;
  logic conv_start, conv_done = 1'b0;
  logic [3:0] conv_chan, gain_factor, irq_pending;
  logic [15:0] res = 16'h0000;
  logic dma_ev = 1'b0, tmr_ev = 1'b0, dio_ev = 1'b0;
  logic brp, dap;
  logic [9:0] depth;
  logic [3:0] chans[64];
  int t_start[64], t_done[64];
  int n_conv = 0, dly = 0, cyc = 0, nb = 0, nd = 0, fails = 0, compares = 0;
  // ==========================================
  // Ends and checker
  daq_bus_if dif (.core_clk(core_clk));
  daq_dev #(.CHAN_W(4), .DEPTH_W(10)) u_daq_dev (.core_clk(core_clk), .rst(rst), .bus(dif),
    .enhanced_mode_pin(enh), .single_ended_pin(1'b1), .ext_trig_a_pin(trig_a),
    .ext_trig_b_pin(trig_b), .conv_start(conv_start), .conv_chan(conv_chan),
    .gain_factor(gain_factor), .conv_done(conv_done), .conv_result(res),
    .dma_event(dma_ev), .timer_event(tmr_ev), .dio_event(dio_ev),
    .board_reset_pulse(brp), .dac_reset_pulse(dap), .buffer_depth(depth),
    .irq_pending(irq_pending));
  daq_host u_daq_host (.core_clk(core_clk), .rst(rst), .bus(dif), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
  daq_bus_asserts u_daq_bus_asserts (.core_clk(core_clk), .rst(rst),
    .bus_addr(dif.bus_addr), .bus_wdata(dif.bus_wdata), .bus_wr(dif.bus_wr),
    .bus_rd(dif.bus_rd), .bus_rdata(dif.bus_rdata), .irq(dif.irq));
  initial forever #12.5 core_clk = ~core_clk;
  // ==========================================
  // Converter stand-in: result tags the channel it was started on
  always @(posedge core_clk) begin
    cyc++;
    conv_done <= 1'b0;
    nb += (brp === 1'b1);
    nd += (dap === 1'b1);
    if (conv_start === 1'b1) begin
      chans[n_conv] = conv_chan;
      t_start[n_conv] = cyc;
      res <= {4'h8, conv_chan, 8'h3C};
      dly = 6;
    end else if (dly != 0) begin
      dly--;
      if (dly == 0) begin
        conv_done <= 1'b1;
        t_done[n_conv] = cyc;
        n_conv++;
      end
    end
  end
  // ==========================================
  // Shared tasks
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cwr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
  endtask
  task automatic crd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge core_clk);
    cmd_rd <= 1'b0;
    #1 d = cmd_rdata;
  endtask
  task automatic run(input logic [7:0] c);
    logic [7:0] s;
    cwr(3'h0, c);
    s = 8'h01;
    for (int i = 0; i < 3000 && s[0] !== 1'b0; i++) crd(3'h4, s);
    check("host idle", 16'h0000, {15'h0000, s[0]});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cwr(3'h1, a);
    cwr(3'h2, d);
    run(8'h02);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cwr(3'h1, a);
    run(8'h04);
    crd(3'h7, d);
    check(n, {8'h00, e}, {8'h00, d});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    rd_chk("chan reset", 8'h02, 8'h00);
    rd_chk("status reset", 8'h03, 8'h40);
    for (int g = 0; g < 4; g++) begin
      wr(8'h03, 8'(g));
      check("gain", 16'(4'h1 << g), {12'h000, gain_factor});
    end
    wr(8'h02, 8'h31);
    check("pointer", 16'h0001, {12'h000, conv_chan});
    rd_chk("chan back", 8'h02, 8'h31);
    $display("test regs done");
  endtask
  task automatic t_single;
    logic [7:0] lo, hi;
    logic [3:0] c;
    for (int k = 0; k < 4; k++) begin
      c = (k == 3) ? 4'h1 : 4'(k + 1);
      run(8'h01);
      crd(3'h5, lo);
      crd(3'h6, hi);
      check("sample", {4'h8, c, 8'h3C}, {hi, lo});
      check("chan used", {12'h000, c}, {12'h000, chans[k]});
    end
    check("conversions", 16'h0004, 16'(n_conv));
    check("depth", 16'h0004, {6'h00, depth});
    $display("test single done");
  endtask
  task automatic scan(input int lo_gap);
    int n0;
    int gap;
    n0 = n_conv;
    run(8'h01);
    check("scan count", 16'h0003, 16'(n_conv - n0));
    for (int k = 0; k < 3; k++) check("scan chan", 16'(k), {12'h000, chans[n0 + k]});
    gap = t_start[n0 + 1] - t_done[n0];
    check("spacing", 16'h0001, 16'(gap >= lo_gap - 1 && gap <= lo_gap + 4));
  endtask
  task automatic t_page;
    wr(8'h01, 8'h02);
    wr(8'h0E, 8'h01);
    rd_chk("page two", 8'h0E, 8'h01);
    wr(8'h01, 8'hA5);
    wr(8'h01, 8'hA6);
    rd_chk("legacy", 8'h0E, 8'h01);
    wr(8'h03, 8'h04);
    rd_chk("shared page", 8'h0E, 8'h00);
    wr(8'h03, 8'h24);
    rd_chk("shared back", 8'h0E, 8'h01);
    wr(8'h02, 8'h20);
    scan(200);
    wr(8'h0E, 8'h00);
    scan(400);
    enh <= 1'b0;
    repeat (5) @(posedge core_clk);
    rd_chk("standard", 8'h0E, 8'h00);
    enh <= 1'b1;
    repeat (5) @(posedge core_clk);
    $display("test page done");
  endtask
  task automatic t_cmds;
    int n0;
    logic [7:0] s;
    wr(8'h00, 8'h10);
    check("depth clear", 16'h0000, {6'h00, depth});
    wr(8'h00, 8'h20);
    check("dac reset", 16'h0001, 16'(nd));
    @(posedge core_clk);
    {dma_ev, tmr_ev, dio_ev} <= 3'h7;
    @(posedge core_clk);
    {dma_ev, tmr_ev, dio_ev} <= 3'h0;
    repeat (3) @(posedge core_clk);
    check("requests", 16'h000E, {12'h000, irq_pending});
    wr(8'h00, 8'h08);
    check("one clear", 16'h0006, {12'h000, irq_pending});
    wr(8'h00, 8'h0F);
    check("all clear", 16'h0000, {12'h000, irq_pending});
    wr(8'h03, 8'h20);
    wr(8'h04, 8'h01);
    n0 = n_conv;
    wr(8'h00, 8'h80);
    repeat (20) @(posedge core_clk);
    check("sw start off", 16'(n0), 16'(n_conv));
    trig_a <= 1'b1;
    repeat (40) @(posedge core_clk);
    trig_a <= 1'b0;
    check("ext start", 16'(n0 + 1), 16'(n_conv));
    check("analog req", 16'h0001, {12'h000, irq_pending});
    crd(3'h4, s);
    check("host irq", 16'h0006, {8'h00, s});
    // Second source selected: the first pin must no longer start anything
    wr(8'h04, 8'h21);
    n0 = n_conv;
    trig_a <= 1'b1;
    repeat (40) @(posedge core_clk);
    check("a ignored", 16'(n0), 16'(n_conv));
    trig_b <= 1'b1;
    repeat (40) @(posedge core_clk);
    {trig_a, trig_b} <= 2'h0;
    check("b start", 16'(n0 + 1), 16'(n_conv));
    wr(8'h00, 8'h40);
    check("board pulse", 16'h0001, 16'(nb));
    check("board req", 16'h0000, {12'h000, irq_pending});
    rd_chk("board chan", 8'h02, 8'h00);
    rd_chk("board ctrl", 8'h04, 8'h00);
    $display("test cmds done");
  endtask
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_regs;
    t_single;
    t_page;
    t_cmds;
    close_out;
  end
endmodule // test_daq_analog_input_command_regs

//--- verilog/daq_bus_if.sv
// Register bus between the host processor and the acquisition block
`timescale 1ns/10ps
interface daq_bus_if (
  input wire logic core_clk
);
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_rdata;
  logic irq;
  modport dev (
    input bus_addr, bus_wdata, bus_wr, bus_rd,
    output bus_rdata, irq
  );
  modport host (
    output bus_addr, bus_wdata, bus_wr, bus_rd,
    input bus_rdata, irq
  );
endinterface

//--- verilog/daq_countdown.sv
// Reloadable down counter used for settling and scan spacing
`timescale 1ns/10ps
module daq_countdown #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic abort,
  // Status
  output logic running,
  output logic expire
);
  logic [W-1:0] count;

  always_ff @(posedge core_clk) begin
    if (rst || abort) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign running = (count != '0);
  assign expire = (count == W'(1)) && !load;
endmodule // daq_countdown

//--- verilog/daq_dev.sv
// Device end: command, sample, channel, gain and scan registers
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "daq_map.svh"
module daq_dev
  import daq_pkg::*;
#(
  parameter int CHAN_W = 4,
  parameter int DEPTH_W = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  daq_bus_if.dev bus,
  // Board configuration pins
  input wire logic enhanced_mode_pin,
  input wire logic single_ended_pin,
  // External trigger pins
  input wire logic ext_trig_a_pin,
  input wire logic ext_trig_b_pin,
  // Converter
  output logic conv_start,
  output logic [CHAN_W-1:0] conv_chan,
  output logic [3:0] gain_factor,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  // Interrupt sources from neighbouring blocks
  input wire logic dma_event,
  input wire logic timer_event,
  input wire logic dio_event,
  // Side effects of commands
  output logic board_reset_pulse,
  output logic dac_reset_pulse,
  output logic [DEPTH_W-1:0] buffer_depth,
  output logic [3:0] irq_pending
);
  localparam int SETTLE_CYC = `DAQ_CYC(`DAQ_SETTLE_NS);
  localparam int SLOW_CYC = `DAQ_CYC(`DAQ_SCAN_SLOW_NS);
  localparam int FAST_CYC = `DAQ_CYC(`DAQ_SCAN_FAST_NS);
  localparam int TW = 10;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] enh_sync;
  logic [1:0] se_sync;
  logic [2:0] trig_a_sync;
  logic [2:0] trig_b_sync;

  always_ff @(posedge core_clk) begin
    enh_sync <= {enh_sync[0], enhanced_mode_pin};
    se_sync <= {se_sync[0], single_ended_pin};
    trig_a_sync <= {trig_a_sync[1:0], ext_trig_a_pin};
    trig_b_sync <= {trig_b_sync[1:0], ext_trig_b_pin};
  end

  // ==========================================================
  // Write decode
  logic [7:0] cmd;
  logic wr_page;
  logic wr_chan;
  logic wr_gain;
  logic wr_ctrl;
  logic wr_spacing;
  logic board_clr;
  logic [1:0] page;
  logic [1:0] eff_page;

  assign cmd = (bus.bus_wr && bus.bus_addr == `DAQ_OFS_CMD) ? bus.bus_wdata : `DAQ_BYTE_ZERO;
  assign board_clr = cmd[`DAQ_CMD_BOARD];
  assign wr_page = bus.bus_wr && bus.bus_addr == `DAQ_OFS_PAGE
    && bus.bus_wdata != `DAQ_LEGACY_A && bus.bus_wdata != `DAQ_LEGACY_B;
  assign wr_chan = bus.bus_wr && bus.bus_addr == `DAQ_OFS_CHAN;
  assign wr_gain = bus.bus_wr && bus.bus_addr == `DAQ_OFS_GAIN;
  assign wr_ctrl = bus.bus_wr && bus.bus_addr == `DAQ_OFS_CTRL;
  assign eff_page = enh_sync[1] ? page : `DAQ_PAGE_RESET;
  assign wr_spacing = bus.bus_wr && bus.bus_addr == `DAQ_OFS_SPACING
    && eff_page == `DAQ_PAGE_SCAN;

  // ==========================================================
  // Configuration registers
  logic [7:0] chan_range;
  logic [1:0] gain_sel;
  logic scan_mode_on;
  logic analog_interrupt_enable;
  logic trigger_source_select;
  logic scan_spacing_select;
  logic [CHAN_W-1:0] low_channel;
  logic [CHAN_W-1:0] high_channel;

  always_ff @(posedge core_clk) begin
    if (rst || board_clr) begin
      page <= `DAQ_PAGE_RESET;
    end else if (wr_page) begin
      page <= bus.bus_wdata[1:0];
    end else if (wr_gain) begin
      page <= bus.bus_wdata[`DAQ_GAIN_PG_HI:`DAQ_GAIN_PG_LO];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || board_clr) begin
      chan_range <= `DAQ_BYTE_ZERO;
      gain_sel <= 2'h0;
      scan_mode_on <= 1'b0;
      analog_interrupt_enable <= 1'b0;
      trigger_source_select <= 1'b0;
      scan_spacing_select <= 1'b0;
    end else begin
      if (wr_chan) begin
        chan_range <= bus.bus_wdata;
      end
      if (wr_gain) begin
        gain_sel <= bus.bus_wdata[1:0];
        scan_mode_on <= bus.bus_wdata[`DAQ_GAIN_SCAN];
      end
      if (wr_ctrl) begin
        analog_interrupt_enable <= bus.bus_wdata[`DAQ_CTRL_ANALOG_INTERRUPT_ENABLE];
        trigger_source_select <= bus.bus_wdata[`DAQ_CTRL_TSEL];
      end
      if (wr_spacing) begin
        scan_spacing_select <= bus.bus_wdata[0];
      end
    end
  end

  assign high_channel = chan_range[7:4];
  assign low_channel = chan_range[3:0];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gain_factor <= 4'h1;
    end else begin
      gain_factor <= 4'h1 << (board_clr ? 2'h0 : gain_sel);
    end
  end

  // ==========================================================
  // Settling and scan spacing timers
  logic settling_flag;
  logic gap_load;
  logic gap_expire;

  daq_countdown #(.W(TW)) u_settle (
    .core_clk(core_clk),
    .rst(rst),
    .load(wr_chan || wr_gain),
    .load_val(TW'(SETTLE_CYC)),
    .abort(board_clr),
    .running(settling_flag),
    .expire()
  );

  daq_countdown #(.W(TW)) u_gap (
    .core_clk(core_clk),
    .rst(rst),
    .load(gap_load),
    .load_val(scan_spacing_select ? TW'(FAST_CYC) : TW'(SLOW_CYC)),
    .abort(board_clr),
    .running(),
    .expire(gap_expire)
  );

  // ==========================================================
  // Conversion sequencer
  daq_conv_e state;
  logic trig;
  logic ext_edge;
  logic last_chan;
  logic conv_end;
  logic [CHAN_W-1:0] next_chan;

  // Only the second and third stages feed the edge detector
  assign ext_edge = trigger_source_select ? (trig_b_sync[1] && !trig_b_sync[2])
                                          : (trig_a_sync[1] && !trig_a_sync[2]);
  assign trig = analog_interrupt_enable ? ext_edge
                                        : cmd[`DAQ_CMD_START];
  assign last_chan = (conv_chan == high_channel);
  assign next_chan = last_chan ? low_channel : conv_chan + 1'b1;
  assign conv_end = (state == DAQ_CONV) && conv_done;
  assign gap_load = conv_end && scan_mode_on && !last_chan;

  always_ff @(posedge core_clk) begin
    if (rst || board_clr) begin
      state <= DAQ_IDLE;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (state)
        DAQ_IDLE: begin
          if (trig) begin
            conv_start <= 1'b1;
            state <= DAQ_CONV;
          end
        end
        DAQ_CONV: begin
          if (conv_done) begin
            state <= gap_load ? DAQ_GAP : DAQ_IDLE;
          end
        end
        DAQ_GAP: begin
          if (gap_expire) begin
            conv_start <= 1'b1;
            state <= DAQ_CONV;
          end
        end
        default: begin
          state <= DAQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || board_clr) begin
      conv_chan <= '0;
    end else if (wr_chan) begin
      conv_chan <= bus.bus_wdata[3:0];
    end else if (conv_end) begin
      conv_chan <= next_chan;
    end
  end

  // Sample and buffer depth
  logic [15:0] sample;

  always_ff @(posedge core_clk) begin
    if (rst || board_clr) begin
      sample <= 16'h0000;
    end else if (conv_end) begin
      sample <= conv_result;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || board_clr || cmd[`DAQ_CMD_BUF]) begin
      buffer_depth <= '0;
    end else if (conv_end) begin
      buffer_depth <= buffer_depth + 1'b1;
    end
  end

  // ==========================================================
  // Interrupt request flip-flops: dma, timer, dio, analog
  logic [3:0] req_set;
  logic [3:0] req_clr;

  assign req_set = {dma_event, timer_event, dio_event,
                    conv_end && !gap_load && analog_interrupt_enable};
  assign req_clr = cmd[`DAQ_CMD_CLR_DMA:`DAQ_CMD_CLR_ANA];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_req
      always_ff @(posedge core_clk) begin
        if (rst || board_clr) begin
          irq_pending[gi] <= 1'b0;
        end else if (req_set[gi]) begin
          irq_pending[gi] <= 1'b1;
        end else if (req_clr[gi]) begin
          irq_pending[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign bus.irq = |irq_pending;

  // ==========================================================
  // Command side effects
  always_ff @(posedge core_clk) begin
    if (rst) begin
      board_reset_pulse <= 1'b0;
      dac_reset_pulse <= 1'b0;
    end else begin
      board_reset_pulse <= board_clr;
      dac_reset_pulse <= cmd[`DAQ_CMD_DAC];
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  daq_byte_t status;

  assign status = {state != DAQ_IDLE, se_sync[1], settling_flag, 2'b00,
                   scan_mode_on, gain_sel};

  always_ff @(posedge core_clk) begin
    if (rst || !bus.bus_rd) begin
      bus.bus_rdata <= `DAQ_BYTE_ZERO;
    end else begin
      case (bus.bus_addr)
        `DAQ_OFS_CMD: bus.bus_rdata <= sample[7:0];
        `DAQ_OFS_PAGE: bus.bus_rdata <= sample[15:8];
        `DAQ_OFS_CHAN: bus.bus_rdata <= chan_range;
        `DAQ_OFS_GAIN: bus.bus_rdata <= status;
        `DAQ_OFS_CTRL: begin
          bus.bus_rdata <= `DAQ_BYTE_ZERO;
          bus.bus_rdata[`DAQ_CTRL_ANALOG_INTERRUPT_ENABLE] <= analog_interrupt_enable;
          bus.bus_rdata[`DAQ_CTRL_TSEL] <= trigger_source_select;
        end
        `DAQ_OFS_SPACING: begin
          bus.bus_rdata <= {7'h00, scan_spacing_select && eff_page == `DAQ_PAGE_SCAN};
        end
        default: bus.bus_rdata <= `DAQ_BYTE_ZERO;
      endcase
    end
  end
endmodule // daq_dev

//--- verilog/daq_host.sv
// Host end: register-programmed bus master for the acquisition block
`timescale 1ns/10ps
`include "daq_map.svh"
module daq_host
  import daq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus to the device
  daq_bus_if.host bus,
  // Software command port
  input wire logic [2:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [7:0] cmd_rdata
);
  daq_host_e state;
  daq_step_e step;
  daq_byte_t raw_addr;
  daq_byte_t raw_data;
  daq_byte_t raw_rd;
  logic [15:0] sample;
  logic done;
  logic go;

  assign go = cmd_wr && cmd_addr == `DAQ_H_CTRL && state == DAQ_H_IDLE;

  // ==========================================================
  // Software registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      raw_addr <= `DAQ_BYTE_ZERO;
      raw_data <= `DAQ_BYTE_ZERO;
    end else if (cmd_wr && cmd_addr == `DAQ_H_RAW_ADDR) begin
      raw_addr <= cmd_wdata;
    end else if (cmd_wr && cmd_addr == `DAQ_H_RAW_DATA) begin
      raw_data <= cmd_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !cmd_rd) begin
      cmd_rdata <= `DAQ_BYTE_ZERO;
    end else begin
      case (cmd_addr)
        `DAQ_H_STATUS: cmd_rdata <= {5'h00, bus.irq, done, state != DAQ_H_IDLE};
        `DAQ_H_SAMPLE_LO: cmd_rdata <= sample[7:0];
        `DAQ_H_SAMPLE_HI: cmd_rdata <= sample[15:8];
        `DAQ_H_RAW_RD: cmd_rdata <= raw_rd;
        default: cmd_rdata <= `DAQ_BYTE_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Bus sequencer: one strobe, then one capture cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= DAQ_H_IDLE;
      step <= DAQ_STEP_RAW;
      bus.bus_wr <= 1'b0;
      bus.bus_rd <= 1'b0;
      bus.bus_addr <= 4'h0;
      bus.bus_wdata <= `DAQ_BYTE_ZERO;
      sample <= 16'h0000;
      raw_rd <= `DAQ_BYTE_ZERO;
      done <= 1'b0;
    end else begin
      bus.bus_wr <= 1'b0;
      bus.bus_rd <= 1'b0;
      case (state)
        DAQ_H_IDLE: begin
          if (go && cmd_wdata[`DAQ_H_GO_SINGLE]) begin
            done <= 1'b0;
            step <= DAQ_STEP_SETTLE;
            bus.bus_rd <= 1'b1;
            bus.bus_addr <= `DAQ_OFS_GAIN;
            state <= DAQ_H_STROBE;
          end else if (go && cmd_wdata[`DAQ_H_GO_RAW_WR]) begin
            step <= DAQ_STEP_WRITE;
            bus.bus_wr <= 1'b1;
            bus.bus_addr <= raw_addr[3:0];
            bus.bus_wdata <= raw_data;
            state <= DAQ_H_STROBE;
          end else if (go && cmd_wdata[`DAQ_H_GO_RAW_RD]) begin
            step <= DAQ_STEP_RAW;
            bus.bus_rd <= 1'b1;
            bus.bus_addr <= raw_addr[3:0];
            state <= DAQ_H_STROBE;
          end
        end
        DAQ_H_STROBE: begin
          state <= (step == DAQ_STEP_WRITE) ? DAQ_H_IDLE : DAQ_H_CAPTURE;
          if (step == DAQ_STEP_WRITE) begin
            done <= 1'b1;
          end
        end
        DAQ_H_CAPTURE: begin
          state <= DAQ_H_STROBE;
          bus.bus_rd <= 1'b1;
          case (step)
            DAQ_STEP_SETTLE: begin
              if (!bus.bus_rdata[`DAQ_STAT_SETTLE]) begin
                bus.bus_rd <= 1'b0;
                bus.bus_wr <= 1'b1;
                bus.bus_addr <= `DAQ_OFS_CMD;
                bus.bus_wdata <= `DAQ_START_VALUE;
                step <= DAQ_STEP_POLL;
                state <= DAQ_H_CAPTURE;
              end
            end
            DAQ_STEP_POLL: begin
              if (bus.bus_wr) begin
                bus.bus_addr <= `DAQ_OFS_GAIN;
              end else if (bus.bus_rdata < `DAQ_BUSY_LIMIT) begin
                bus.bus_addr <= `DAQ_OFS_CMD;
                step <= DAQ_STEP_LO;
              end
            end
            DAQ_STEP_LO: begin
              sample[7:0] <= bus.bus_rdata;
              bus.bus_addr <= `DAQ_OFS_PAGE;
              step <= DAQ_STEP_HI;
            end
            DAQ_STEP_HI: begin
              sample[15:8] <= bus.bus_rdata;
              bus.bus_rd <= 1'b0;
              done <= 1'b1;
              state <= DAQ_H_IDLE;
            end
            default: begin
              raw_rd <= bus.bus_rdata;
              bus.bus_rd <= 1'b0;
              done <= 1'b1;
              state <= DAQ_H_IDLE;
            end
          endcase
        end
        default: begin
          state <= DAQ_H_IDLE;
        end
      endcase
    end
  end
endmodule // daq_host

//--- verilog/daq_map.svh
// Offsets, bit positions, reset values and timing for the acquisition registers
`ifndef DAQ_MAP_SVH
`define DAQ_MAP_SVH
// ==========================================================
// Device register offsets
`define DAQ_OFS_CMD 4'h0
`define DAQ_OFS_PAGE 4'h1
`define DAQ_OFS_CHAN 4'h2
`define DAQ_OFS_GAIN 4'h3
`define DAQ_OFS_CTRL 4'h4
`define DAQ_OFS_SPACING 4'hE
// ==========================================================
// Command trigger bits
`define DAQ_CMD_START 7
`define DAQ_CMD_BOARD 6
`define DAQ_CMD_DAC 5
`define DAQ_CMD_BUF 4
`define DAQ_CMD_CLR_DMA 3
`define DAQ_CMD_CLR_TMR 2
`define DAQ_CMD_CLR_DIO 1
`define DAQ_CMD_CLR_ANA 0
// ==========================================================
// Field positions
`define DAQ_GAIN_PG_HI 5
`define DAQ_GAIN_PG_LO 4
`define DAQ_GAIN_SCAN 2
`define DAQ_CTRL_ANALOG_INTERRUPT_ENABLE 0
`define DAQ_CTRL_TSEL 5
`define DAQ_STAT_BUSY 7
`define DAQ_STAT_SE 6
`define DAQ_STAT_SETTLE 5
`define DAQ_LEGACY_A 8'hA5
`define DAQ_LEGACY_B 8'hA6
`define DAQ_PAGE_SCAN 2'h2
`define DAQ_PAGE_RESET 2'h0
`define DAQ_BYTE_ZERO 8'h00
// ==========================================================
// Timing, in ns, and cycles at the core clock (rounded up)
`define DAQ_CLK_NS 25
`define DAQ_SETTLE_NS 10000
`define DAQ_SCAN_SLOW_NS 10000
`define DAQ_SCAN_FAST_NS 5000
`define DAQ_CYC(ns) (((ns) + `DAQ_CLK_NS - 1) / `DAQ_CLK_NS)
// ==========================================================
// Host controller register offsets and values
`define DAQ_H_CTRL 3'h0
`define DAQ_H_RAW_ADDR 3'h1
`define DAQ_H_RAW_DATA 3'h2
`define DAQ_H_STATUS 3'h4
`define DAQ_H_SAMPLE_LO 3'h5
`define DAQ_H_SAMPLE_HI 3'h6
`define DAQ_H_RAW_RD 3'h7
`define DAQ_H_GO_SINGLE 0
`define DAQ_H_GO_RAW_WR 1
`define DAQ_H_GO_RAW_RD 2
`define DAQ_START_VALUE 8'h80
`define DAQ_BUSY_LIMIT 8'h80
`endif

//--- verilog/daq_pkg.sv
// Shared types of the acquisition register block
package daq_pkg;
  typedef enum logic [1:0] {
    DAQ_IDLE,
    DAQ_CONV,
    DAQ_GAP
  } daq_conv_e;
  typedef enum logic [1:0] {
    DAQ_H_IDLE,
    DAQ_H_STROBE,
    DAQ_H_CAPTURE
  } daq_host_e;
  typedef enum logic [2:0] {
    DAQ_STEP_SETTLE,
    DAQ_STEP_POLL,
    DAQ_STEP_LO,
    DAQ_STEP_HI,
    DAQ_STEP_RAW,
    DAQ_STEP_WRITE
  } daq_step_e;
  typedef logic [7:0] daq_byte_t;
endpackage
